// ### logic/btf_regs.vh
// register offsets, field positions and reset values of the trace unit
`ifndef BTF_REGS_VH
`define BTF_REGS_VH
// ---------------------------------------------------------------
// register offsets (12-bit register address)
// ---------------------------------------------------------------
`define BTF_MSR_DEBUGCTL 12'h1D9
`define BTF_MSR_GSTATUS 12'h38E
`define BTF_MSR_OVFCLR 12'h390
`define BTF_MSR_GENABLE 12'h3A0
`define BTF_MSR_EVSEL0 12'h3B0
`define BTF_MSR_EVSEL1 12'h3B1
`define BTF_MSR_FIXCTL 12'h3B8
`define BTF_MSR_CTR_BASE 12'h3C0
`define BTF_MSR_STORE 12'h3D0
`define BTF_MSR_LBR_TOS 12'h3E0
`define BTF_MSR_LBR_BASE 12'h3E8
// ---------------------------------------------------------------
// debug_control_reg fields
// ---------------------------------------------------------------
`define BTF_DBG_LBR 0
`define BTF_DBG_TR 6
`define BTF_DBG_BTS 7
`define BTF_DBG_TRACE_BUFFER_INTERRUPT_ENABLE 8
`define BTF_DBG_OFF_OS 9
`define BTF_DBG_OFF_USR 10
`define BTF_DBG_FRZ_LBR 11
`define BTF_DBG_FRZ_CTR 12
`define BTF_DBG_MASK 13'h1FC1
`define BTF_DBG_RST 13'h0000
// ---------------------------------------------------------------
// counter control and status fields
// ---------------------------------------------------------------
`define BTF_EVSEL_INT 20
`define BTF_EVSEL_EN 22
`define BTF_FIX_EN 0
`define BTF_FIX_INT 3
`define BTF_GEN_FIX0 32
`define BTF_ST_FIX0 32
`define BTF_ST_STORE 40
`define BTF_ST_SAMPLE 41
`define BTF_ST_BRANCH_FREEZE_STATUS 42
`define BTF_ST_COUNTER_FREEZE_STATUS 43
`define BTF_GEN_RST 4'h0
`define BTF_CTR_W 32
// ---------------------------------------------------------------
// capability and record encodings
// ---------------------------------------------------------------
`define BTF_CAP_PRIV_FILTER 4
`define BTF_KIND_BRANCH 2'h0
`define BTF_KIND_IRQ 2'h1
`define BTF_KIND_EXC 2'h2
`define BTF_LEGACY_MIN 8'h02
`define BTF_LEGACY_MAX 8'h03
`define BTF_STREAM_MIN 8'h04
`endif

// ### logic/btf_counter.v
// one performance counter with load port and overflow pulse
`timescale 1ns/1ns
`include "btf_regs.vh"
module btf_counter (
  input wire clk_i,
  input wire rst_i,
  input wire count_i,
  input wire load_i,
  input wire [`BTF_CTR_W-1:0] load_val_i,
  output wire [`BTF_CTR_W-1:0] value_o,
  output wire ovf_o
);
  reg [`BTF_CTR_W-1:0] cnt_q;
  reg ovf_q;

  always @(posedge clk_i) begin
    if (rst_i) begin
      cnt_q <= {`BTF_CTR_W{1'b0}};
      ovf_q <= 1'b0;
    end else begin
      // a software load wins over a count in the same cycle
      if (load_i) begin
        cnt_q <= load_val_i;
      end else if (count_i) begin
        cnt_q <= cnt_q + {{(`BTF_CTR_W-1){1'b0}}, 1'b1};
      end
      ovf_q <= ~load_i & count_i & (&cnt_q);
    end
  end

  assign value_o = cnt_q;
  assign ovf_o = ovf_q;
endmodule // btf_counter

// ### logic/btf_msg_gen.v
// turns one branch event into one or two trace records
`timescale 1ns/1ns
`include "btf_regs.vh"
module btf_msg_gen (
  input wire clk_i,
  input wire rst_i,
  input wire load_i,
  input wire [31:0] from_i,
  input wire [31:0] to_i,
  input wire [1:0] kind_i,
  input wire with_irq_i,
  input wire adv_i,
  output wire idle_o,
  output wire rec_valid_o,
  output wire [65:0] rec_o
);
  localparam ST_IDLE = 2'h0;
  localparam ST_MAIN = 2'h1;
  localparam ST_EXTRA = 2'h2;
  reg [1:0] state_q;
  reg [65:0] rec_q;
  reg irq_q;

  always @(posedge clk_i) begin
    if (rst_i) begin
      state_q <= ST_IDLE;
      rec_q <= 66'h0;
      irq_q <= 1'b0;
    end else begin
      case (state_q)
        ST_IDLE: begin
          if (load_i) begin
            rec_q <= {kind_i, to_i, from_i};
            irq_q <= with_irq_i;
            state_q <= ST_MAIN;
          end
        end
        ST_MAIN: begin
          if (adv_i) begin
            if (irq_q) begin
              // extra record for the coinciding interrupt
              rec_q <= {`BTF_KIND_IRQ, rec_q[63:32], rec_q[31:0]};
              state_q <= ST_EXTRA;
            end else begin
              state_q <= ST_IDLE;
            end
          end
        end
        ST_EXTRA: begin
          if (adv_i) begin
            state_q <= ST_IDLE;
          end
        end
        default: begin
          state_q <= ST_IDLE;
        end
      endcase
    end
  end

  assign idle_o = (state_q == ST_IDLE);
  assign rec_valid_o = (state_q != ST_IDLE);
  assign rec_o = rec_q;
endmodule // btf_msg_gen

// ### logic/btf_core.v
// branch trace, branch record stack and freeze-on-interrupt unit
// What this block does
// - with trace messages on, send a bus record per taken branch or event.
// - a branch coinciding with an interrupt sends an extra bus record.
// - older variant: trace messages on means branch stack is not recorded.
// - newer variant: branch stack records alongside trace messages.
// - branch record enable captures branches and events into the stack.
// - trace store writes memory buffer; interrupt at threshold, else circular.
// - two privilege filter bits suppress bus messages and store records.
// - supervisor filter skips tracing at privilege level zero.
// - user filter skips tracing at privilege levels above zero.
// - a capability bit reads one to show privilege filtering exists.
// - freeze features exist only for monitoring version two or higher.
// - legacy branch freeze clears the record enable; software re-arms.
// - streamlined branch freeze sets a status bit, enable untouched.
// - legacy counter freeze clears the global counter enable register.
// - streamlined counter freeze sets a status bit, enable untouched.
// - freeze triggers: enabled counter overflow or buffer threshold hits.
// - general counter interrupts only with its select interrupt bit set.
// - fixed counter interrupts only with bit three of its field set.
// - writing ones to the overflow clear register clears status bits.
// - overflow clear writes clear status in both flavours.
`timescale 1ns/1ns
`include "btf_regs.vh"
module btf_core #(
  parameter [7:0] PERF_ARCH_VERSION = 8'h04,
  parameter COMBINED_TRACE_LBR = 1
) (
  input wire clk_i,
  input wire rst_i,
  input wire msr_wr_i,
  input wire msr_rd_i,
  input wire [11:0] msr_addr_i,
  input wire [63:0] msr_wdata_i,
  output wire [63:0] msr_rdata_o,
  output wire msr_rvalid_o,
  output wire msr_err_o,
  input wire br_valid_i,
  output wire br_ready_o,
  input wire [31:0] br_from_i,
  input wire [31:0] br_to_i,
  input wire [1:0] br_kind_i,
  input wire br_irq_i,
  input wire [1:0] cpl_i,
  output wire bus_msg_valid_o,
  input wire bus_msg_ready_i,
  output wire [65:0] bus_msg_o,
  output wire store_valid_o,
  input wire store_ready_i,
  output wire [15:0] store_addr_o,
  output wire [65:0] store_data_o,
  input wire [1:0] gp_event_i,
  input wire [1:0] fix_event_i,
  input wire sample_thresh_i,
  output wire [31:0] cap_flags_o,
  output wire lbr_active_o,
  output wire ctr_frozen_o,
  output wire pmi_o
);
  // ---------------------------------------------------------------
  // state
  // ---------------------------------------------------------------
  reg [12:0] dbg_q;
  reg [12:0] dbg_d;
  reg [3:0] gen_q;
  reg [3:0] gen_d;
  reg [3:0] ovf_st_q;
  reg st_store_q;
  reg st_sample_q;
  reg branch_freeze_status_q;
  reg counter_freeze_status_q;
  reg [31:0] evsel0_q;
  reg [31:0] evsel1_q;
  reg [7:0] fixctl_q;
  reg [15:0] idx_q;
  reg [15:0] idx_d;
  reg [15:0] thr_q;
  reg [15:0] lim_q;
  reg [31:0] lbr_from_q [0:3];
  reg [31:0] lbr_to_q [0:3];
  reg [1:0] tos_q;
  reg snd_bus_q;
  reg snd_store_q;
  reg store_hit_q;
  reg pmi_q;
  reg [63:0] rdata_q;
  reg [63:0] rdata_d;
  reg rvalid_q;
  reg err_q;
  reg map_d;
  wire [3:0] ctr_ovf;
  wire [4*`BTF_CTR_W-1:0] ctr_val;
  wire [3:0] ctr_run;
  wire [3:0] ctr_int;
  wire [3:0] ctr_ld;
  wire em_idle;
  wire em_valid;
  wire [65:0] em_rec;
  wire em_adv;
  wire br_take;
  wire skip;
  wire trace_on;
  wire lbr_rec;
  wire store_full;
  wire store_take;
  wire legacy;
  wire stream;
  wire trig;
  wire wr_dbg;
  wire wr_gen;
  wire wr_clr;
  wire wr_store;
  integer i;

  // ---------------------------------------------------------------
  // flavour and filter decode
  // ---------------------------------------------------------------
  // freeze hardware is absent below version two
  assign legacy = (PERF_ARCH_VERSION >= `BTF_LEGACY_MIN) &&
                  (PERF_ARCH_VERSION <= `BTF_LEGACY_MAX);
  assign stream = (PERF_ARCH_VERSION >= `BTF_STREAM_MIN);
  assign skip = (dbg_q[`BTF_DBG_OFF_OS] && (cpl_i == 2'h0)) ||
                (dbg_q[`BTF_DBG_OFF_USR] && (cpl_i != 2'h0));
  assign trace_on = (dbg_q[`BTF_DBG_TR] | dbg_q[`BTF_DBG_BTS]) & ~skip;
  // older variant leaves the stack alone while messages run
  assign lbr_rec = dbg_q[`BTF_DBG_LBR] & ~branch_freeze_status_q &
                   ((COMBINED_TRACE_LBR != 0) | ~dbg_q[`BTF_DBG_TR]);
  assign cap_flags_o = 32'h1 << `BTF_CAP_PRIV_FILTER;
  assign lbr_active_o = lbr_rec;
  assign ctr_frozen_o = counter_freeze_status_q;

  // ---------------------------------------------------------------
  // branch events and record emission
  // ---------------------------------------------------------------
  // a new event waits until every record of the last one is out
  assign br_ready_o = em_idle;
  assign br_take = br_valid_i & em_idle;

  btf_msg_gen u_msg (
    .clk_i(clk_i),
    .rst_i(rst_i),
    .load_i(br_take & trace_on),
    .from_i(br_from_i),
    .to_i(br_to_i),
    .kind_i(br_kind_i),
    .with_irq_i(br_irq_i),
    .adv_i(em_adv),
    .idle_o(em_idle),
    .rec_valid_o(em_valid),
    .rec_o(em_rec)
  );

  // a full non-circular buffer drops records rather than stall the core
  assign store_full = dbg_q[`BTF_DBG_TRACE_BUFFER_INTERRUPT_ENABLE] && (idx_q == lim_q);
  assign bus_msg_valid_o = em_valid & snd_bus_q;
  assign bus_msg_o = em_rec;
  assign store_valid_o = em_valid & snd_store_q & ~store_full;
  assign store_data_o = em_rec;
  assign store_addr_o = idx_q;
  assign store_take = store_valid_o & store_ready_i;
  assign em_adv = em_valid & (~snd_bus_q | bus_msg_ready_i) &
                  (~snd_store_q | store_full | store_ready_i);

  always @(posedge clk_i) begin
    if (rst_i) begin
      snd_bus_q <= 1'b0;
      snd_store_q <= 1'b0;
    end else if (br_take) begin
      // filtered levels send and store nothing
      snd_bus_q <= dbg_q[`BTF_DBG_TR] & ~skip;
      snd_store_q <= dbg_q[`BTF_DBG_BTS] & ~skip;
    end
  end

  // ---------------------------------------------------------------
  // last branch record stack
  // ---------------------------------------------------------------
  always @(posedge clk_i) begin
    if (rst_i) begin
      tos_q <= 2'h0;
      for (i = 0; i < 4; i = i + 1) begin
        lbr_from_q[i] <= 32'h0;
        lbr_to_q[i] <= 32'h0;
      end
    end else if (br_take && lbr_rec) begin
      tos_q <= tos_q + 2'h1;
      lbr_from_q[tos_q + 2'h1] <= br_from_i;
      lbr_to_q[tos_q + 2'h1] <= br_to_i;
    end
  end

  // ---------------------------------------------------------------
  // counters
  // ---------------------------------------------------------------
  // streamlined freeze stops counting without touching enables
  assign ctr_run[0] = gen_q[0] & evsel0_q[`BTF_EVSEL_EN] & ~counter_freeze_status_q;
  assign ctr_run[1] = gen_q[1] & evsel1_q[`BTF_EVSEL_EN] & ~counter_freeze_status_q;
  assign ctr_run[2] = gen_q[2] & fixctl_q[`BTF_FIX_EN] & ~counter_freeze_status_q;
  assign ctr_run[3] = gen_q[3] & fixctl_q[4+`BTF_FIX_EN] & ~counter_freeze_status_q;
  assign ctr_int[0] = evsel0_q[`BTF_EVSEL_INT];
  assign ctr_int[1] = evsel1_q[`BTF_EVSEL_INT];
  assign ctr_int[2] = fixctl_q[`BTF_FIX_INT];
  assign ctr_int[3] = fixctl_q[4+`BTF_FIX_INT];

  genvar g;
  generate
    for (g = 0; g < 4; g = g + 1) begin : g_ctr
      assign ctr_ld[g] = msr_wr_i &&
        (msr_addr_i == `BTF_MSR_CTR_BASE + g);
      btf_counter u_ctr (
        .clk_i(clk_i),
        .rst_i(rst_i),
        .count_i(ctr_run[g] &
                 (g < 2 ? gp_event_i[g % 2] : fix_event_i[g % 2])),
        .load_i(ctr_ld[g]),
        .load_val_i(msr_wdata_i[`BTF_CTR_W-1:0]),
        .value_o(ctr_val[g*`BTF_CTR_W +: `BTF_CTR_W]),
        .ovf_o(ctr_ovf[g])
      );
    end
  endgenerate

  // ---------------------------------------------------------------
  // freeze trigger
  // ---------------------------------------------------------------
  // overflow with interrupt enabled, or either buffer threshold
  assign trig = (|(ctr_ovf & ctr_int)) | store_hit_q | sample_thresh_i;
  assign pmi_o = pmi_q;

  // ---------------------------------------------------------------
  // register writes
  // ---------------------------------------------------------------
  assign wr_dbg = msr_wr_i && (msr_addr_i == `BTF_MSR_DEBUGCTL);
  assign wr_gen = msr_wr_i && (msr_addr_i == `BTF_MSR_GENABLE);
  assign wr_clr = msr_wr_i && (msr_addr_i == `BTF_MSR_OVFCLR);
  assign wr_store = msr_wr_i && (msr_addr_i == `BTF_MSR_STORE);

  always @* begin
    dbg_d = wr_dbg ? (msr_wdata_i[12:0] & `BTF_DBG_MASK) : dbg_q;
    // hardware clear beats a same-cycle write so the freeze holds
    if (legacy && trig && dbg_q[`BTF_DBG_FRZ_LBR]) begin
      dbg_d[`BTF_DBG_LBR] = 1'b0;
    end
    // software re-enables counting by rewriting these bits
    gen_d = wr_gen ? {msr_wdata_i[`BTF_GEN_FIX0+1],
                      msr_wdata_i[`BTF_GEN_FIX0],
                      msr_wdata_i[1:0]} : gen_q;
    if (legacy && trig && dbg_q[`BTF_DBG_FRZ_CTR]) begin
      gen_d = 4'h0;
    end
    idx_d = idx_q;
    if (store_take) begin
      // wrap at the limit when no interrupt is wanted
      if (!dbg_q[`BTF_DBG_TRACE_BUFFER_INTERRUPT_ENABLE] && (idx_q == lim_q)) begin
        idx_d = 16'h0;
      end else begin
        idx_d = idx_q + 16'h1;
      end
    end
    if (wr_store) begin
      idx_d = msr_wdata_i[15:0];
    end
  end

  always @(posedge clk_i) begin
    if (rst_i) begin
      dbg_q <= `BTF_DBG_RST;
      gen_q <= `BTF_GEN_RST;
      evsel0_q <= 32'h0;
      evsel1_q <= 32'h0;
      fixctl_q <= 8'h0;
      idx_q <= 16'h0;
      thr_q <= 16'h0;
      lim_q <= 16'h0;
      store_hit_q <= 1'b0;
      pmi_q <= 1'b0;
    end else begin
      dbg_q <= dbg_d;
      gen_q <= gen_d;
      idx_q <= idx_d;
      pmi_q <= trig;
      // threshold reached on the write that lands on it
      store_hit_q <= store_take & dbg_q[`BTF_DBG_TRACE_BUFFER_INTERRUPT_ENABLE] &
                     ((idx_q + 16'h1) == thr_q);
      if (msr_wr_i && (msr_addr_i == `BTF_MSR_EVSEL0)) begin
        evsel0_q <= msr_wdata_i[31:0];
      end
      if (msr_wr_i && (msr_addr_i == `BTF_MSR_EVSEL1)) begin
        evsel1_q <= msr_wdata_i[31:0];
      end
      if (msr_wr_i && (msr_addr_i == `BTF_MSR_FIXCTL)) begin
        fixctl_q <= msr_wdata_i[7:0];
      end
      if (wr_store) begin
        thr_q <= msr_wdata_i[31:16];
        lim_q <= msr_wdata_i[47:32];
      end
    end
  end

  // ---------------------------------------------------------------
  // global status: hardware set wins over the clear write
  // ---------------------------------------------------------------
  always @(posedge clk_i) begin
    if (rst_i) begin
      ovf_st_q <= 4'h0;
      st_store_q <= 1'b0;
      st_sample_q <= 1'b0;
      branch_freeze_status_q <= 1'b0;
      counter_freeze_status_q <= 1'b0;
    end else begin
      // ones written to the clear register drop status bits
      ovf_st_q <= ctr_ovf | (ovf_st_q & ~({4{wr_clr}} &
                  {msr_wdata_i[`BTF_ST_FIX0+1], msr_wdata_i[`BTF_ST_FIX0],
                   msr_wdata_i[1:0]}));
      st_store_q <= store_hit_q |
        (st_store_q & ~(wr_clr & msr_wdata_i[`BTF_ST_STORE]));
      st_sample_q <= sample_thresh_i |
        (st_sample_q & ~(wr_clr & msr_wdata_i[`BTF_ST_SAMPLE]));
      branch_freeze_status_q <= (stream & trig & dbg_q[`BTF_DBG_FRZ_LBR]) |
        (branch_freeze_status_q & ~(wr_clr & msr_wdata_i[`BTF_ST_BRANCH_FREEZE_STATUS]));
      counter_freeze_status_q <= (stream & trig & dbg_q[`BTF_DBG_FRZ_CTR]) |
        (counter_freeze_status_q & ~(wr_clr & msr_wdata_i[`BTF_ST_COUNTER_FREEZE_STATUS]));
    end
  end

  // ---------------------------------------------------------------
  // register reads, answered one cycle after the request
  // ---------------------------------------------------------------
  always @* begin
    rdata_d = 64'h0;
    map_d = 1'b1;
    case (msr_addr_i)
      `BTF_MSR_DEBUGCTL: rdata_d[12:0] = dbg_q;
      `BTF_MSR_GSTATUS: begin
        // handler reads this to find the overflowed counters
        rdata_d[1:0] = ovf_st_q[1:0];
        rdata_d[`BTF_ST_FIX0+1:`BTF_ST_FIX0] = ovf_st_q[3:2];
        rdata_d[`BTF_ST_STORE] = st_store_q;
        rdata_d[`BTF_ST_SAMPLE] = st_sample_q;
        rdata_d[`BTF_ST_BRANCH_FREEZE_STATUS] = branch_freeze_status_q;
        rdata_d[`BTF_ST_COUNTER_FREEZE_STATUS] = counter_freeze_status_q;
      end
      `BTF_MSR_OVFCLR: rdata_d = 64'h0;
      `BTF_MSR_GENABLE: begin
        rdata_d[1:0] = gen_q[1:0];
        rdata_d[`BTF_GEN_FIX0+1:`BTF_GEN_FIX0] = gen_q[3:2];
      end
      `BTF_MSR_EVSEL0: rdata_d[31:0] = evsel0_q;
      `BTF_MSR_EVSEL1: rdata_d[31:0] = evsel1_q;
      `BTF_MSR_FIXCTL: rdata_d[7:0] = fixctl_q;
      `BTF_MSR_STORE: rdata_d[47:0] = {lim_q, thr_q, idx_q};
      `BTF_MSR_LBR_TOS: rdata_d[1:0] = tos_q;
      default: begin
        if (msr_addr_i[11:2] == `BTF_MSR_CTR_BASE >> 2) begin
          rdata_d[`BTF_CTR_W-1:0] =
            ctr_val[msr_addr_i[1:0]*`BTF_CTR_W +: `BTF_CTR_W];
        end else if (msr_addr_i[11:2] == `BTF_MSR_LBR_BASE >> 2) begin
          rdata_d = {lbr_to_q[msr_addr_i[1:0]],
                     lbr_from_q[msr_addr_i[1:0]]};
        end else begin
          map_d = 1'b0;
        end
      end
    endcase
  end

  always @(posedge clk_i) begin
    if (rst_i) begin
      rdata_q <= 64'h0;
      rvalid_q <= 1'b0;
      err_q <= 1'b0;
    end else begin
      rvalid_q <= msr_rd_i;
      rdata_q <= msr_rd_i ? rdata_d : 64'h0;
      // unmapped reads and writes flag an error and return zero
      err_q <= (msr_rd_i | msr_wr_i) & ~map_d;
    end
  end

  assign msr_rdata_o = rdata_q;
  assign msr_rvalid_o = rvalid_q;
  assign msr_err_o = err_q;
endmodule // btf_core

// ### bench/btf_trace_sink.sv
// far-side sink model: trace monitor on the bus, or trace memory
`timescale 1ns/1ns
module btf_trace_sink (
  input wire clk_i,
  input wire rst_i,
  input wire stall_i,
  input wire valid_i,
  input wire [65:0] data_i,
  input wire [15:0] addr_i,
  output reg ready_o,
  output reg [7:0] count_o,
  output reg [65:0] last_o,
  output reg [15:0] addr_o
);
  // ---------------------------------------------------------------
  // acceptance
  // ---------------------------------------------------------------
  // slow mode accepts every other cycle, so the unit must hold records
  always @(posedge clk_i) begin
    if (rst_i) begin
      ready_o <= 1'b0;
      count_o <= 8'h00;
      last_o <= 66'h0;
      addr_o <= 16'h0000;
    end else begin
      ready_o <= !stall_i || !ready_o;
      if (valid_i && ready_o) begin
        count_o <= count_o + 8'h01;
        last_o <= data_i;
        addr_o <= addr_i;
      end
    end
  end
endmodule // btf_trace_sink

// ### bench/btf_core_monitor.sv
// port assertions for the trace and freeze unit
`timescale 1ns/1ns
`include "btf_regs.vh"
module btf_core_monitor (
  input wire clk_i,
  input wire rst_i,
  input wire msr_wr_i,
  input wire msr_rd_i,
  input wire [11:0] msr_addr_i,
  input wire [63:0] msr_wdata_i,
  input wire [63:0] msr_rdata_o,
  input wire msr_rvalid_o,
  input wire msr_err_o,
  input wire br_ready_o,
  input wire bus_msg_valid_o,
  input wire bus_msg_ready_i,
  input wire [65:0] bus_msg_o,
  input wire store_valid_o,
  input wire store_ready_i,
  input wire [65:0] store_data_o,
  input wire [1:0] gp_event_i,
  input wire [1:0] fix_event_i,
  input wire sample_thresh_i,
  input wire [31:0] cap_flags_o,
  input wire ctr_frozen_o,
  input wire pmi_o
);
  // ---------------------------------------------------------------
  // properties
  // ---------------------------------------------------------------
  wire clr_frz = msr_wr_i && msr_addr_i == `BTF_MSR_OVFCLR && msr_wdata_i[43];
  // a fresh trigger in the clear cycle may legally win, so exclude it
  wire quiet = gp_event_i == 2'h0 && fix_event_i == 2'h0 && !sample_thresh_i;
  default clocking cb @(posedge clk_i);
  endclocking
  default disable iff (rst_i);
  a_read_answer: assert property (msr_rd_i |=> msr_rvalid_o || msr_err_o)
    else $error("read got no answer");
  a_read_quiet: assert property (!msr_rd_i |=> !msr_rvalid_o && msr_rdata_o == 64'h0)
    else $error("read data without a read");
  a_status_mapped: assert property (msr_rd_i && msr_addr_i == `BTF_MSR_GSTATUS |=> msr_rvalid_o && !msr_err_o)
    else $error("status read refused");
  a_cap_flag: assert property (cap_flags_o == 32'h00000010)
    else $error("capability flags wrong");
  a_msg_hold: assert property (bus_msg_valid_o && !bus_msg_ready_i |=> bus_msg_valid_o && $stable(bus_msg_o))
    else $error("bus message dropped or changed");
  a_store_hold: assert property (store_valid_o && !store_ready_i |=> store_valid_o && $stable(store_data_o))
    else $error("store write dropped or changed");
  a_busy_refuse: assert property (bus_msg_valid_o || store_valid_o |-> !br_ready_o)
    else $error("event taken while records pending");
  a_sample_pmi: assert property (sample_thresh_i |-> ##1 pmi_o)
    else $error("sampling threshold gave no interrupt");
  a_frz_hold: assert property (ctr_frozen_o && !clr_frz |=> ctr_frozen_o)
    else $error("counter freeze lost without clear");
  a_frz_clear: assert property (clr_frz && quiet |=> !ctr_frozen_o)
    else $error("counter freeze not cleared");
endmodule // btf_core_monitor
bind btf_core btf_core_monitor btf_core_monitor_i (.*);

// ### bench/btf_core_tb.sv
// self-checking bench for the trace and freeze unit
`timescale 1ns/1ns
`include "btf_regs.vh"
module btf_core_tb;
  typedef struct packed {
    logic [11:0] addr;
    logic [63:0] wdata;
    logic [63:0] rdata;
  } btf_row_t;
  localparam logic [63:0] ONES = {64{1'b1}};
  logic clk_i, rst_i, msr_wr_i, msr_rd_i, br_valid_i, br_irq_i, stall, e;
  logic sample_thresh_i;
  logic [11:0] msr_addr_i;
  logic [63:0] msr_wdata_i, v;
  logic [31:0] br_from_i, br_to_i;
  logic [1:0] br_kind_i, cpl_i, gp_event_i, fix_event_i;
  logic [7:0] c;
  wire [63:0] msr_rdata_o;
  wire msr_rvalid_o, msr_err_o, br_ready_o, bus_msg_valid_o, store_valid_o;
  wire lbr_active_o, ctr_frozen_o, pmi_o, bus_msg_ready_i, store_ready_i;
  wire [65:0] bus_msg_o, store_data_o, bus_last;
  wire [15:0] store_addr_o, st_addr;
  wire [31:0] cap_flags_o;
  wire [7:0] bus_cnt, st_cnt;
  int mismatches, comparisons, cycles, pmi_cnt, i;
  btf_row_t rows [7];
  btf_core btf_core_i (.*);
  btf_trace_sink btf_trace_sink_i (.clk_i(clk_i), .rst_i(rst_i),
    .stall_i(stall), .valid_i(bus_msg_valid_o), .data_i(bus_msg_o),
    .addr_i(16'h0000), .ready_o(bus_msg_ready_i), .count_o(bus_cnt),
    .last_o(bus_last), .addr_o());
  btf_trace_sink btf_trace_sink_st_i (.clk_i(clk_i), .rst_i(rst_i),
    .stall_i(stall), .valid_i(store_valid_o), .data_i(store_data_o),
    .addr_i(store_addr_o), .ready_o(store_ready_i), .count_o(st_cnt),
    .last_o(), .addr_o(st_addr));
  // ---------------------------------------------------------------
  // tasks
  // ---------------------------------------------------------------
  task final_report;
    if (mismatches == 0 && comparisons > 0)
      $display("SIMULATION PASSED");
    else
      $display("SIMULATION FAILED");
    $finish;
  endtask
  task tick;
    @(posedge clk_i);
    #1;
  endtask
  task chk(input [65:0] seen, input [65:0] exp);
    comparisons++;
    if (seen !== exp) begin
      mismatches++;
      $display("CHECK FAILED t=%0t seen=%h exp=%h", $time, seen, exp);
    end
  endtask
  // strobes drop a full cycle before the next task may raise them again
  task wr(input [11:0] a, input [63:0] d);
    msr_wr_i = 1'b1;
    msr_addr_i = a;
    msr_wdata_i = d;
    tick;
    msr_wr_i = 1'b0;
    tick;
  endtask
  task rd(input [11:0] a);
    msr_rd_i = 1'b1;
    msr_addr_i = a;
    tick;
    msr_rd_i = 1'b0;
    v = msr_rdata_o;
    e = msr_err_o;
    tick;
  endtask
  task rdc(input [11:0] a, input [63:0] exp);
    rd(a);
    chk(v, exp);
  endtask
  task idle;
    int n;
    n = 0;
    while (br_ready_o !== 1'b1 && n < 100) begin
      tick;
      n++;
    end
  endtask
  task br(input [31:0] f, input [31:0] t, input [1:0] k, input q);
    idle;
    br_valid_i = 1'b1;
    br_from_i = f;
    br_to_i = t;
    br_kind_i = k;
    br_irq_i = q;
    tick;
    br_valid_i = 1'b0;
    tick;
    idle;
  endtask
  task ovf(input [11:0] ca, input [63:0] cv, input [63:0] ge,
           input [11:0] na, input [1:0] gp, input [1:0] fx, input sm,
           input [63:0] st, input int np, input [31:0] cx);
    int p0;
    p0 = pmi_cnt;
    wr(`BTF_MSR_DEBUGCTL, 64'h1801);
    wr(ca, cv);
    wr(`BTF_MSR_GENABLE, ge);
    wr(na, {32'h0, ONES[31:0]});
    gp_event_i = gp;
    fix_event_i = fx;
    sample_thresh_i = sm;
    tick;
    gp_event_i = 2'h0;
    fix_event_i = 2'h0;
    sample_thresh_i = 1'b0;
    repeat (4) tick;
    rdc(`BTF_MSR_GSTATUS, st);
    chk(pmi_cnt - p0, np);
    chk(ctr_frozen_o, st[43]);
    chk(lbr_active_o, !st[42]);
    rdc(`BTF_MSR_DEBUGCTL, 64'h1801);
    rdc(`BTF_MSR_GENABLE, ge);
    gp_event_i = gp;
    tick;
    gp_event_i = 2'h0;
    tick;
    rdc(na, {32'h0, cx});
    wr(`BTF_MSR_OVFCLR, st);
    rdc(`BTF_MSR_GSTATUS, 64'h0);
    chk(ctr_frozen_o, 1'b0);
  endtask
  // ---------------------------------------------------------------
  // clock, timeout and stimulus
  // ---------------------------------------------------------------
  initial begin
    clk_i = 1'b0;
    forever #4 clk_i = ~clk_i;
  end
  always @(posedge clk_i) begin
    cycles++;
    if (pmi_o === 1'b1)
      pmi_cnt++;
    if (cycles == 20000) begin
      mismatches++;
      final_report;
    end
  end
  initial begin
    {msr_wr_i, msr_rd_i, br_valid_i, br_irq_i, stall, sample_thresh_i} = 0;
    {msr_addr_i, msr_wdata_i, br_from_i, br_to_i, br_kind_i} = 0;
    {cpl_i, gp_event_i, fix_event_i} = 0;
    rst_i = 1'b1;
    rows[0] = '{`BTF_MSR_DEBUGCTL, ONES, 64'h1FC1};
    rows[1] = '{`BTF_MSR_DEBUGCTL, 64'h0, 64'h0};
    rows[2] = '{`BTF_MSR_GENABLE, ONES, 64'h3_0000_0003};
    rows[3] = '{`BTF_MSR_EVSEL0, ONES, 64'hFFFF_FFFF};
    rows[4] = '{12'h3C1, 64'hAB_1234_5678, 64'h1234_5678};
    rows[5] = '{`BTF_MSR_GSTATUS, ONES, 64'h0};
    rows[6] = '{`BTF_MSR_OVFCLR, ONES, 64'h0};
    repeat (5) @(posedge clk_i);
    #1;
    rst_i = 1'b0;
    chk(br_ready_o, 1'b1);
    chk(cap_flags_o, 32'h10);
    rdc(`BTF_MSR_DEBUGCTL, 64'h0);
    foreach (rows[j]) begin
      wr(rows[j].addr, rows[j].wdata);
      rdc(rows[j].addr, rows[j].rdata);
    end
    rd(12'h123);
    chk({e, v}, {1'b1, 64'h0});
    // every record kind on the bus, then the branch stack beside it
    wr(`BTF_MSR_DEBUGCTL, 64'h41);
    cpl_i = 2'h3;
    for (i = 0; i < 3; i++) begin
      br(32'h100 + i, 32'h200 + i, i[1:0], 1'b0);
      chk(bus_last, {i[1:0], 32'h200 + i, 32'h100 + i});
    end
    rd(`BTF_MSR_LBR_TOS);
    rdc(`BTF_MSR_LBR_BASE + {10'h0, v[1:0]}, {32'h202, 32'h102});
    stall = 1'b1;
    c = bus_cnt;
    br(32'h3000, 32'h4000, `BTF_KIND_BRANCH, 1'b1);
    chk(bus_cnt - c, 8'h02);
    chk(bus_last, {`BTF_KIND_IRQ, 32'h4000, 32'h3000});
    // privilege filter: user off at 3 and 0, supervisor off at 0 and 1
    for (i = 0; i < 4; i++) begin
      wr(`BTF_MSR_DEBUGCTL, i < 2 ? 64'h440 : 64'h240);
      cpl_i = i == 0 ? 2'h3 : (i == 3 ? 2'h1 : 2'h0);
      c = bus_cnt;
      br(32'h500, 32'h600, `BTF_KIND_BRANCH, 1'b0);
      chk(bus_cnt - c, {7'h0, i[0]});
    end
    // circular store with limit 1, then a threshold hit with interrupt
    wr(`BTF_MSR_DEBUGCTL, 64'h80);
    wr(`BTF_MSR_STORE, 64'h0001_0000_0000);
    for (i = 0; i < 3; i++) begin
      br(32'h700, 32'h800, `BTF_KIND_BRANCH, 1'b0);
      chk(st_addr, {15'h0, i == 1});
    end
    c = pmi_cnt;
    wr(`BTF_MSR_DEBUGCTL, 64'h180);
    wr(`BTF_MSR_STORE, 64'h0003_0002_0000);
    br(32'h700, 32'h800, `BTF_KIND_BRANCH, 1'b0);
    br(32'h700, 32'h800, `BTF_KIND_BRANCH, 1'b0);
    repeat (3) tick;
    rdc(`BTF_MSR_GSTATUS, 64'h100_0000_0000);
    chk(pmi_cnt - c, 8'h01);
    wr(`BTF_MSR_OVFCLR, ONES);
    stall = 1'b0;
    ovf(`BTF_MSR_EVSEL0, 64'h40_0000, 64'h1, `BTF_MSR_CTR_BASE, 2'h1, 2'h0,
        1'b0, 64'h1, 0, 32'h1);
    ovf(`BTF_MSR_EVSEL0, 64'h50_0000, 64'h1, `BTF_MSR_CTR_BASE, 2'h1, 2'h0,
        1'b0, 64'hC00_0000_0001, 1, 32'h0);
    ovf(`BTF_MSR_FIXCTL, 64'h9, 64'h1_0000_0000, 12'h3C2, 2'h0, 2'h1,
        1'b0, 64'hC01_0000_0000, 1, 32'h0);
    ovf(`BTF_MSR_EVSEL0, 64'h0, 64'h0, 12'h3C1, 2'h0, 2'h0,
        1'b1, 64'hE00_0000_0000, 1, ONES[31:0]);
    final_report;
  end
endmodule // btf_core_tb
